/* logic/ctap_top.sv */
// Configuration test port: instruction, bypass, identification and
// configuration registers behind a four-pin serial port.
// Assumes pins are asynchronous to clock and far slower than it.
module ctap_top #(
  parameter logic [31:0] ID_VALUE = ctap_pkg::ID_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input ctap_pkg::ctap_pins_t pins,
  output logic tdo_q,
  output logic tdo_oe_q,
  input wire logic [95:0] cfg_current,
  output logic [95:0] cfg_shift_q,
  output ctap_pkg::ctap_op_t op_start_q,
  output logic [4:0] instr_q
);
  // ===========================================================
  // Two-stage synchronisers for pins
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic tck_prev_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      tck_prev_q <= sync2_q[2];
    end
  end
  logic tck_s, tms_s, tdi_s, rise, fall;
  assign tck_s = sync2_q[2];
  assign tms_s = sync2_q[1];
  assign tdi_s = sync2_q[0];
  assign rise = tck_s && !tck_prev_q; // R1
  assign fall = !tck_s && tck_prev_q; // R1
  // ===========================================================
  // Controller
  ctap_pkg::ctap_state_t st;
  ctap_fsm u_fsm (
    .clock(clock),
    .rst(rst),
    .step(rise),
    .tms(tms_s),
    .state_q(st)
  );
  // ===========================================================
  // Path selection from current instruction
  function automatic logic [1:0] sel_path(input logic [4:0] ins);
    case (ins)
      ctap_pkg::INS_IDREAD: sel_path = 2'h1; // R22
      ctap_pkg::INS_SEL_CFG, ctap_pkg::INS_VERIFY_A, ctap_pkg::INS_VERIFY_B,
      ctap_pkg::INS_PROGRAM_A, ctap_pkg::INS_PROGRAM_B: sel_path = 2'h2; // R23
      default: sel_path = 2'h0; // R15 R16
    endcase
  endfunction
  logic [1:0] path;
  assign path = sel_path(instr_q);
  // ===========================================================
  // Instruction shift stage and latched instruction
  logic [4:0] ir_sh_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ir_sh_q <= ctap_pkg::INS_IDREAD;
      instr_q <= ctap_pkg::INS_IDREAD;
    end else if (rise) begin
      case (st)
        ctap_pkg::ST_RESET: instr_q <= ctap_pkg::INS_IDREAD; // R25 R20
        // Entering reset from select-IR loads the identification code at once
        ctap_pkg::ST_SEL_IR: begin
          if (tms_s) begin
            instr_q <= ctap_pkg::INS_IDREAD; // R25
          end
        end
        ctap_pkg::ST_CAP_IR: ir_sh_q <= ctap_pkg::INS_IDREAD; // R8
        ctap_pkg::ST_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[4:1]}; // R13
        default: ir_sh_q <= ir_sh_q; // R10
      endcase
    end else if (fall && st == ctap_pkg::ST_UPD_IR) begin
      // New instruction takes effect while in update, not on leaving it
      instr_q <= ir_sh_q; // R12
    end
  end
  // ===========================================================
  // Bypass, identification and configuration shift stages
  logic byp_q;
  logic [31:0] id_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byp_q <= 1'b0;
      id_q <= 32'h0000_0000;
    end else if (rise) begin
      if (st == ctap_pkg::ST_CAP_DR) begin
        byp_q <= 1'b0; // R7
        id_q <= ID_VALUE; // R20
      end else if (st == ctap_pkg::ST_SH_DR) begin
        byp_q <= tdi_s; // R14 R17
        id_q <= {tdi_s, id_q[31:1]};
      end
    end
  end
  // Configuration register shifts only when selected; verify loads store
  logic verify_pend_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_shift_q <= 96'h0;
    end else if (verify_pend_q && rise && st == ctap_pkg::ST_IDLE) begin
      cfg_shift_q <= cfg_current; // R19
    end else if (rise && st == ctap_pkg::ST_SH_DR && path == 2'h2) begin
      cfg_shift_q <= {tdi_s, cfg_shift_q[95:1]}; // R21 R18
    end
  end
  // ===========================================================
  // Deferred operations: armed at instruction update, fired entering idle
  logic idle_entry;
  assign idle_entry = rise && (st == ctap_pkg::ST_UPD_IR || st == ctap_pkg::ST_UPD_DR)
    && !tms_s;
  logic armed_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      verify_pend_q <= 1'b0;
      op_start_q <= '0;
    end else begin
      op_start_q <= '0; // R6
      // Verify request waits for the first rise spent in idle
      if (rise && st == ctap_pkg::ST_IDLE) begin
        verify_pend_q <= 1'b0; // R19
      end
      // Any instruction update arms, even when a data scan follows
      if (rise && st == ctap_pkg::ST_UPD_IR) begin
        armed_q <= 1'b1; // R11
      end else if (rise && st == ctap_pkg::ST_RESET) begin
        armed_q <= 1'b0;
      end
      if (idle_entry && (armed_q || st == ctap_pkg::ST_UPD_IR)) begin
        armed_q <= 1'b0;
        op_start_q.program_a <= ir_sh_q == ctap_pkg::INS_PROGRAM_A; // R11
        op_start_q.program_b <= ir_sh_q == ctap_pkg::INS_PROGRAM_B;
        op_start_q.erase_a <= ir_sh_q == ctap_pkg::INS_ERASE_A;
        op_start_q.erase_b <= ir_sh_q == ctap_pkg::INS_ERASE_B;
        op_start_q.verify_a <= ir_sh_q == ctap_pkg::INS_VERIFY_A;
        op_start_q.verify_b <= ir_sh_q == ctap_pkg::INS_VERIFY_B;
        op_start_q.calib <= ir_sh_q == ctap_pkg::INS_CALIB;
        verify_pend_q <= ir_sh_q == ctap_pkg::INS_VERIFY_A ||
          ir_sh_q == ctap_pkg::INS_VERIFY_B;
      end
    end
  end
  // ===========================================================
  // Serial output, changed on falling edge, driven only while shifting
  logic tdo_d;
  always_comb begin
    tdo_d = byp_q;
    if (st == ctap_pkg::ST_SH_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (path == 2'h1) begin
      tdo_d = id_q[0];
    end else if (path == 2'h2) begin
      tdo_d = cfg_shift_q[0];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (fall) begin
      tdo_q <= tdo_d; // R1
      tdo_oe_q <= st == ctap_pkg::ST_SH_DR || st == ctap_pkg::ST_SH_IR; // R24
    end
  end
  // ===========================================================
  // Checks
  a_reset_idcode: assert property (@(posedge clock) disable iff (rst) // R25
    rise && st == ctap_pkg::ST_RESET |=> instr_q == ctap_pkg::INS_IDREAD)
    else $error("reset did not select identification");
  a_capture_ir: assert property (@(posedge clock) disable iff (rst) // R8
    rise && st == ctap_pkg::ST_CAP_IR |=> ir_sh_q == ctap_pkg::INS_IDREAD)
    else $error("capture-ir code wrong");
  a_oe_shift: assert property (@(posedge clock) disable iff (rst) // R24
    fall && !(st inside {ctap_pkg::ST_SH_DR, ctap_pkg::ST_SH_IR}) |=> !tdo_oe_q)
    else $error("output enabled outside shift");
  a_op_at_idle: assert property (@(posedge clock) disable iff (rst) // R11
    op_start_q != '0 |-> $past(idle_entry)) else $error("op started off idle entry");
  a_bypass_pass: assert property (@(posedge clock) disable iff (rst) // R14
    rise && st == ctap_pkg::ST_SH_DR |=> byp_q == $past(tdi_s))
    else $error("bypass stage did not capture");
  a_id_capture: assert property (@(posedge clock) disable iff (rst) // R20
    rise && st == ctap_pkg::ST_CAP_DR |=> id_q == ID_VALUE)
    else $error("identification not captured");
  a_instr_update: assert property (@(posedge clock) disable iff (rst) // R12
    fall && st == ctap_pkg::ST_UPD_IR |=> instr_q == $past(ir_sh_q))
    else $error("instruction not taken at update");
  c_program: cover property (@(posedge clock) disable iff (rst) op_start_q.program_a);
  c_verify: cover property (@(posedge clock) disable iff (rst) op_start_q.verify_b);
  c_cfg_shift: cover property (@(posedge clock) disable iff (rst)
    rise && st == ctap_pkg::ST_SH_DR && path == 2'h2);
endmodule

/* common/ctap_pkg.sv */
// Constants, state and instruction types for the configuration test port.
// Assumes a single system clock that samples the slow test clock pins.
// Behaviour
// R1 - Sample inputs rising edge, drive output falling
// R2 - Sixteen-state controller stepped by sampled mode
// R3 - Five mode-high edges always reach reset
// R4 - Controller starts in reset without edges
// R5 - Six states hold under steady mode
// R6 - Reset exits to idle; idle does nothing
// R7 - Capture-DR loads selected data register
// R8 - Capture-IR loads identification-read code
// R9 - Capture to shift or exit1, then update/pause
// R10 - Pause holds path; exit2 resumes or updates
// R11 - Program, erase, verify start entering idle
// R12 - Other instructions act at instruction update; calibrate here starts entering idle instead
// R13 - Instruction register is five bits
// R14 - Bypass is one single-bit stage
// R15 - Boundary-scan instructions select bypass instead
// R16 - Bypass all ones, external test zeros
// R17 - Bypass passes data, device undisturbed
// R18 - Master selects, shifts, then programs
// R19 - Verify loads configuration for shift-out
// R20 - Identification register 32 bits, ready at reset
// R21 - Configuration shift register is 96 bits
// R22 - Identification-read code 01101 selects identification
// R23 - Configuration-select code 00001 selects config path
// R24 - Output driven only in shift states
// R25 - Reset state loads identification-read instruction
package ctap_pkg;
  // ===========================================================
  // Widths
  localparam int IR_W = 5;
  localparam int ID_W = 32;
  localparam int CFG_W = 96;
  // ===========================================================
  // Instruction codes
  localparam logic [4:0] INS_EXTEST = 5'h00;
  localparam logic [4:0] INS_SEL_CFG = 5'h01;
  localparam logic [4:0] INS_ERASE_A = 5'h02;
  localparam logic [4:0] INS_ERASE_B = 5'h03;
  localparam logic [4:0] INS_VERIFY_A = 5'h04;
  localparam logic [4:0] INS_VERIFY_B = 5'h05;
  localparam logic [4:0] INS_PROGRAM_A = 5'h06;
  localparam logic [4:0] INS_PROGRAM_B = 5'h07;
  localparam logic [4:0] INS_CALIB = 5'h0C;
  localparam logic [4:0] INS_IDREAD = 5'h0D;
  localparam logic [4:0] INS_SAMPLE = 5'h1E;
  localparam logic [4:0] INS_BYPASS = 5'h1F;
  // Identification word, value arbitrary
  localparam logic [31:0] ID_DEFAULT = 32'h1234_5671;
  // ===========================================================
  // Controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
    ST_EX2_IR, ST_UPD_IR
  } ctap_state_t;
  // Operation request towards the non-volatile store
  typedef struct packed {
    logic program_a;
    logic program_b;
    logic erase_a;
    logic erase_b;
    logic verify_a;
    logic verify_b;
    logic calib;
  } ctap_op_t;
  // Pin group from the master
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } ctap_pins_t;
endpackage

/* logic/ctap_fsm.sv */
// Sixteen-state test port controller stepped by a rising-edge strobe.
// Assumes tms is already synchronised to clock.
module ctap_fsm (
  input wire logic clock,
  input wire logic rst,
  input wire logic step,
  input wire logic tms,
  output ctap_pkg::ctap_state_t state_q
);
  // ===========================================================
  // Next state from mode level
  ctap_pkg::ctap_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ctap_pkg::ST_RESET: state_d = tms ? ctap_pkg::ST_RESET : ctap_pkg::ST_IDLE; // R6
      ctap_pkg::ST_IDLE: state_d = tms ? ctap_pkg::ST_SEL_DR : ctap_pkg::ST_IDLE;
      ctap_pkg::ST_SEL_DR: state_d = tms ? ctap_pkg::ST_SEL_IR : ctap_pkg::ST_CAP_DR;
      ctap_pkg::ST_CAP_DR: state_d = tms ? ctap_pkg::ST_EX1_DR : ctap_pkg::ST_SH_DR; // R9
      ctap_pkg::ST_SH_DR: state_d = tms ? ctap_pkg::ST_EX1_DR : ctap_pkg::ST_SH_DR;
      ctap_pkg::ST_EX1_DR: state_d = tms ? ctap_pkg::ST_UPD_DR : ctap_pkg::ST_PA_DR;
      ctap_pkg::ST_PA_DR: state_d = tms ? ctap_pkg::ST_EX2_DR : ctap_pkg::ST_PA_DR;
      ctap_pkg::ST_EX2_DR: state_d = tms ? ctap_pkg::ST_UPD_DR : ctap_pkg::ST_SH_DR; // R10
      ctap_pkg::ST_UPD_DR: state_d = tms ? ctap_pkg::ST_SEL_DR : ctap_pkg::ST_IDLE;
      ctap_pkg::ST_SEL_IR: state_d = tms ? ctap_pkg::ST_RESET : ctap_pkg::ST_CAP_IR; // R3
      ctap_pkg::ST_CAP_IR: state_d = tms ? ctap_pkg::ST_EX1_IR : ctap_pkg::ST_SH_IR;
      ctap_pkg::ST_SH_IR: state_d = tms ? ctap_pkg::ST_EX1_IR : ctap_pkg::ST_SH_IR;
      ctap_pkg::ST_EX1_IR: state_d = tms ? ctap_pkg::ST_UPD_IR : ctap_pkg::ST_PA_IR;
      ctap_pkg::ST_PA_IR: state_d = tms ? ctap_pkg::ST_EX2_IR : ctap_pkg::ST_PA_IR;
      ctap_pkg::ST_EX2_IR: state_d = tms ? ctap_pkg::ST_UPD_IR : ctap_pkg::ST_SH_IR;
      ctap_pkg::ST_UPD_IR: state_d = tms ? ctap_pkg::ST_SEL_DR : ctap_pkg::ST_IDLE;
      default: state_d = ctap_pkg::ST_RESET;
    endcase
  end
  // ===========================================================
  // State register, advanced only on test clock rising edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ctap_pkg::ST_RESET; // R4
    end else if (step) begin
      state_q <= state_d; // R2 R5
    end
  end
  // Five steps with mode high must reach reset
  logic [2:0] hi_cnt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= 3'h0;
    end else if (step) begin
      hi_cnt_q <= !tms ? 3'h0 : (hi_cnt_q == 3'h5 ? 3'h5 : hi_cnt_q + 3'h1);
    end
  end
  a_five_high_reset: assert property (@(posedge clock) disable iff (rst) // R3
    hi_cnt_q == 3'h5 |-> state_q == ctap_pkg::ST_RESET) else $error("no reset after five");
  a_reset_holds: assert property (@(posedge clock) disable iff (rst) // R3
    step && tms && state_q == ctap_pkg::ST_RESET |=> state_q == ctap_pkg::ST_RESET)
    else $error("reset state left with mode high");
  a_capture_next: assert property (@(posedge clock) disable iff (rst) // R9
    step && state_q == ctap_pkg::ST_CAP_DR |=>
    state_q inside {ctap_pkg::ST_SH_DR, ctap_pkg::ST_EX1_DR})
    else $error("bad capture exit");
  a_pause_exit: assert property (@(posedge clock) disable iff (rst) // R10
    step && state_q == ctap_pkg::ST_EX2_IR && !tms |=> state_q == ctap_pkg::ST_SH_IR)
    else $error("exit2 did not resume shift");
  c_pause_dr: cover property (@(posedge clock) disable iff (rst)
    state_q == ctap_pkg::ST_PA_DR);
endmodule

/* testbench/ctap_master_model.sv */
// Behavioural serial test master driving the four-pin port.
// Assumes the bench clock is 100 ns; one test clock period is 8 of them.
module ctap_master_model (
  input wire logic clock,
  output ctap_pkg::ctap_pins_t pins,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Pin driver
  // Test clock rests low between frames
  initial pins = '0;
  // One test clock period; returns tdo seen just before the rise
  task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
    @(negedge clock);
    pins.tms = tms_v;
    pins.tdi = tdi_v;
    repeat (3) @(negedge clock);
    // Released line reads as the inverse so it never passes for data
    tdo_v = tdo_oe ? tdo : ~tdo;
    pins.tck = 1'b1;
    repeat (4) @(negedge clock);
    pins.tck = 1'b0;
    // Data hold has run out: show the inverse, not the last value
    pins.tdi = ~pins.tdi;
  endtask
endmodule

/* testbench/tb_ctap_top.sv */
// Self-checking bench for the configuration test port.
// Assumes ctap_pkg is compiled first and the master model drives the pins.
module tb_ctap_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals
  logic clock;
  logic rst;
  ctap_pkg::ctap_pins_t pins;
  logic tdo_q;
  logic tdo_oe_q;
  logic [95:0] cfg_current;
  logic [95:0] cfg_shift_q;
  ctap_pkg::ctap_op_t op_start_q;
  logic [4:0] instr_q;
  ctap_pkg::ctap_op_t op_seen; // Sticky record of op pulses
  logic op_clr; // Clears the op record at the next clock
  int mismatches;
  int total_checks;
  logic b;
  logic [95:0] d;
  // ==========================================
  // Instances
  ctap_top ctap_top_inst (.clock(clock), .rst(rst), .pins(pins), .tdo_q(tdo_q),
    .tdo_oe_q(tdo_oe_q), .cfg_current(cfg_current), .cfg_shift_q(cfg_shift_q),
    .op_start_q(op_start_q), .instr_q(instr_q));
  ctap_master_model ctap_master_model_inst (.clock(clock), .pins(pins), .tdo(tdo_q),
    .tdo_oe(tdo_oe_q));
  // Clock generator
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Collect single-cycle op pulses
  always @(posedge clock) op_seen <= op_clr ? '0 : (op_seen | op_start_q);
  // ==========================================
  // Shared tasks
  task automatic check_vec(input string what, input logic [95:0] exp, input logic [95:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input logic tms_v, input logic tdi_v = 1'b0);
    ctap_master_model_inst.tick(tms_v, tdi_v, b);
  endtask
  // From idle to a shift state
  task automatic go_shift(input logic ir);
    tk(1'b1);
    if (ir) tk(1'b1);
    tk(1'b0);
    tk(1'b0);
  endtask
  // Shift n bits LSB first, ending in exit1, with an optional pause
  task automatic shift(input int n, input logic [95:0] din, input int pause_at);
    d = 'z;
    for (int i = 0; i < n; i++) begin
      ctap_master_model_inst.tick(i == n - 1 || i == pause_at, din[i], b);
      d[i] = b;
      if (i == pause_at) begin
        tk(1'b0);
        tk(1'b0);
        check_vec("tdo_oe in pause", 96'h0, {95'h0, tdo_oe_q});
        tk(1'b1);
        tk(1'b0);
      end
    end
  endtask
  function automatic ctap_pkg::ctap_op_t exp_op(input logic [4:0] c);
    case (c)
      ctap_pkg::INS_PROGRAM_A: exp_op = 7'h40;
      ctap_pkg::INS_PROGRAM_B: exp_op = 7'h20;
      ctap_pkg::INS_ERASE_A: exp_op = 7'h10;
      ctap_pkg::INS_ERASE_B: exp_op = 7'h08;
      ctap_pkg::INS_VERIFY_A: exp_op = 7'h04;
      ctap_pkg::INS_VERIFY_B: exp_op = 7'h02;
      ctap_pkg::INS_CALIB: exp_op = 7'h01;
      default: exp_op = 7'h00;
    endcase
  endfunction
  // Instruction scan from idle; op pulses only on return to idle
  task automatic load_ir(input logic [4:0] c);
    @(negedge clock) op_clr = 1'b1;
    @(negedge clock) op_clr = 1'b0;
    go_shift(1'b1);
    shift(5, {91'h0, c}, -1);
    check_vec("ir capture", {91'h0, ctap_pkg::INS_IDREAD}, {91'h0, d[4:0]});
    tk(1'b1);
    // Let the falling edge in update pass the pin synchroniser
    repeat (3) @(negedge clock);
    check_vec("op at update", 96'h0, {89'h0, op_seen});
    check_vec("instr", {91'h0, c}, {91'h0, instr_q});
    tk(1'b0);
    repeat (3) @(negedge clock);
    check_vec("op", {89'h0, exp_op(c)}, {89'h0, op_seen});
  endtask
  task automatic dr_scan(input int n, input logic [95:0] din, input int pause_at);
    go_shift(1'b0);
    shift(n, din, pause_at);
    tk(1'b1);
    tk(1'b0);
  endtask
  // ==========================================
  // Scenarios
  task automatic test_id();
    check_vec("reset instr", {91'h0, ctap_pkg::INS_IDREAD}, {91'h0, instr_q});
    tk(1'b0);
    dr_scan(32, '0, -1);
    check_vec("id", {64'h0, ctap_pkg::ID_DEFAULT}, {64'h0, d[31:0]});
    $display("test id done");
  endtask
  task automatic test_bypass();
    logic [4:0] codes [3] = '{ctap_pkg::INS_EXTEST, ctap_pkg::INS_SAMPLE, ctap_pkg::INS_BYPASS};
    foreach (codes[k]) begin
      load_ir(codes[k]);
      dr_scan(8, 96'hA5, -1);
      check_vec("bypass", 96'h4A, {88'h0, d[7:0]});
    end
    $display("test bypass done");
  endtask
  task automatic test_cfg();
    logic [95:0] pat = 96'hF0E1_D2C3_B4A5_9687_7869_5A4B;
    load_ir(ctap_pkg::INS_SEL_CFG);
    dr_scan(96, pat, 40);
    check_vec("cfg shift", pat, cfg_shift_q);
    for (int c = 2; c < 8; c++) load_ir(c[4:0]);
    load_ir(ctap_pkg::INS_CALIB);
    $display("test cfg done");
  endtask
  task automatic test_verify();
    @(negedge clock) cfg_current = 96'h0123_4567_89AB_CDEF_FEDC_BA98;
    load_ir(ctap_pkg::INS_VERIFY_B);
    tk(1'b0);
    load_ir(ctap_pkg::INS_SEL_CFG);
    dr_scan(96, '0, -1);
    check_vec("verify", 96'h0123_4567_89AB_CDEF_FEDC_BA98, d);
    $display("test verify done");
  endtask
  task automatic test_reset5();
    go_shift(1'b0);
    repeat (5) tk(1'b1);
    repeat (3) @(negedge clock);
    check_vec("instr after reset", {91'h0, ctap_pkg::INS_IDREAD}, {91'h0, instr_q});
    check_vec("tdo_oe after reset", 96'h0, {95'h0, tdo_oe_q});
    tk(1'b0);
    dr_scan(32, '0, -1);
    check_vec("id again", {64'h0, ctap_pkg::ID_DEFAULT}, {64'h0, d[31:0]});
    $display("test reset5 done");
  endtask
  // ==========================================
  // Verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    cfg_current = '0;
    op_clr = 1'b1;
    mismatches = 0;
    total_checks = 0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    op_clr = 1'b0;
    repeat (3) @(negedge clock);
    test_id();
    test_bypass();
    test_cfg();
    test_verify();
    test_reset5();
    complete_run();
  end
  // Watchdog, well beyond the expected run of under a millisecond
  initial begin
    #3000000;
    mismatches++;
    complete_run();
  end
endmodule
